// ===== hdl/gxp_debounce.sv
// Debouncer with change pulse for the keyboard scan port
`timescale 1ns/1ps
`default_nettype none
module gxp_debounce
    import gxp_pkg::*;
#(
    parameter int W   = PORT_W,               // Number of inputs
    parameter int CYC = DEB_CYC               // Stable cycles needed
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] raw,
    output logic      [W-1:0] level_q,
    output logic              change_q
);
    localparam int CW = $clog2(CYC + 1);
    localparam logic [CW-1:0] CNT_END = CW'(CYC);

    // Refuse a zero debounce time
    if (CYC < 1) begin : g_chk
        $error("gxp_debounce: CYC must be at least one");
    end

    logic [W-1:0] diff;                       // Raw differs from level
    logic [W-1:0] settle;                     // Input held long enough

    // One counter per input, restarted whenever the input bounces back
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic [CW-1:0] cnt_q;                 // Stable time so far
        assign diff[i]   = raw[i] ^ level_q[i];
        assign settle[i] = diff[i] && (cnt_q == CNT_END - CW'(1));
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_q <= '0;
            end else if (ce) begin
                cnt_q <= (diff[i] && !settle[i]) ? cnt_q + CW'(1) : '0;
            end
        end
    end

    // Accept settled inputs and pulse once in each cycle that accepts a change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q  <= '0;
            change_q <= 1'b0;
        end else if (ce) begin
            level_q  <= level_q ^ settle;     // see RULE10
            change_q <= |settle;              // see RULE16
        end
    end

    // A pulse always goes with a new debounced level
    change_level_a: assert property ( // see RULE16
        @(posedge pclk) disable iff (!presetn)
        ($past(ce) && change_q) |-> level_q != $past(level_q))
        else $error("change pulse without level change");
endmodule
`default_nettype wire

// ===== hdl/gxp_gpio.sv
// Six-port GPIO block with APB register access
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1 - Forty-eight pins in six ports, each configurable
// RULE2 - Direction bit one makes output, zero input
// RULE3 - Input pin read returns live pin level
// RULE4 - Input write one selects pull-up; port C zero pull-down
// RULE5 - Other ports: cleared input bit means no pull
// RULE6 - Misc bit seven gates pull-ups of other ports
// RULE7 - Port C type bit enables chosen pull resistor
// RULE8 - Output pin drives written value, reads it back
// RULE9 - Port C type zero open-drain, one push-pull
// RULE10 - Port A debounced with transition request
// RULE11 - Ports C, D, E switched by function selects
// RULE12 - Port L is display's unless display powered off
// RULE13 - Function switch keeps direction and type settings
// RULE14 - Software sets direction, type before function switch
// RULE15 - Eight-bit ports with own direction, data, selects
// RULE16 - Request when any debounced port A input changes
module gxp_gpio
    import gxp_pkg::*;
#(
    parameter int DEB_CYCLES = DEB_CYC        // Port A debounce count
) (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          ce,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [ADDR_W-1:0]             paddr,
    input  wire logic [31:0]                   pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [NPORT-1:0][PORT_W-1:0]  pin_in,
    input  wire logic [NPORT-1:0][PORT_W-1:0]  alt_drv,
    output logic      [NPORT-1:0][PORT_W-1:0]  alt_sel_q,
    output gxp_pad_t  [NPORT-1:0]              pad_q,
    output logic                               porta_irq_q
);
    // Refuse a debounce time the counter cannot serve
    if (DEB_CYCLES < 1) begin : g_chk
        $error("gxp_gpio: DEB_CYCLES must be at least one");
    end

    // Pads leave reset as undriven inputs without pulls
    localparam gxp_pad_t PAD_RST = '{drv: '0, oe_n: '1, pu: '0, pd: '0};

    // Address match on word index, low two bits ignored
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] off);
        addr_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction

    // Software-visible state
    logic [NPORT-1:0][PORT_W-1:0] dir_q;      // Direction per port
    logic [NPORT-1:0][PORT_W-1:0] val_q;      // Written value per port
    logic [PORT_W-1:0]            ctype_q;    // Port C type select
    logic [PORT_W-1:0]            cfunc_q;    // Port C function select
    logic [PORT_W-1:0]            dfunc_q;    // Port D function select
    logic [PORT_W-1:0]            misc_q;     // Port misc control
    logic [PORT_W-1:0]            disp_q;     // Display control

    // Bus side decode
    logic                         setup;      // Setup cycle seen
    logic                         wr_en;      // Write commits this edge
    logic [NPORT-1:0]             hit_dir;    // Direction reg addressed
    logic [NPORT-1:0]             hit_val;    // Value reg addressed
    logic                         hit_ctype;
    logic                         hit_cfunc;
    logic                         hit_dfunc;
    logic                         hit_misc;
    logic                         hit_disp;
    logic                         mapped;     // Any register addressed
    logic [PORT_W-1:0]            wbyte;      // Byte written
    logic [NPORT-1:0][PORT_W-1:0] rd_val;     // Value as read back
    logic [PORT_W-1:0]            rd_byte;    // Selected read byte

    // Pad side
    logic [NPORT-1:0][PORT_W-1:0] alt_sel_d;  // Pins lent to functions
    gxp_pad_t [NPORT-1:0]         pad_d;      // Next pad drive
    logic                         pull_en;    // Global pull-up enable
    logic [PORT_W-1:0]            deb_level;  // Debounced port A
    logic                         deb_change; // Port A level change

    // A setup cycle loads the answer; the access phase then completes
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && pready && ce && pstrb[0];
    assign wbyte = pwdata[PORT_W-1:0];

    // Per-port register decode and read-back
    for (genvar i = 0; i < NPORT; i++) begin : g_dec
        localparam logic [ADDR_W-1:0] STEP = ADDR_W'(i * PORT_STEP);
        assign hit_dir[i] = addr_hit(paddr, OFF_DIR + STEP);
        assign hit_val[i] = addr_hit(paddr, OFF_VAL + STEP);
        // Input pins show the pad, output pins the stored value
        assign rd_val[i]  = (dir_q[i] & val_q[i])      // see RULE8
                          | (~dir_q[i] & pin_in[i]);   // see RULE3
    end

    assign hit_ctype = addr_hit(paddr, OFF_CTYPE);
    assign hit_cfunc = addr_hit(paddr, OFF_CFUNC);
    assign hit_dfunc = addr_hit(paddr, OFF_DFUNC);
    assign hit_misc  = addr_hit(paddr, OFF_MISC);
    assign hit_disp  = addr_hit(paddr, OFF_DISP);
    assign mapped    = |{hit_dir, hit_val, hit_ctype, hit_cfunc,
                         hit_dfunc, hit_misc, hit_disp};

    // Read byte selection; unmapped addresses read zero
    always_comb begin
        rd_byte = RST_BYTE;
        for (int i = 0; i < NPORT; i++) begin
            if (hit_dir[i]) begin
                rd_byte = dir_q[i];
            end
            if (hit_val[i]) begin
                rd_byte = rd_val[i];
            end
        end
        if (hit_ctype) begin
            rd_byte = ctype_q;
        end
        if (hit_cfunc) begin
            rd_byte = cfunc_q;
        end
        if (hit_dfunc) begin
            rd_byte = dfunc_q;
        end
        if (hit_misc) begin
            rd_byte = misc_q;
        end
        if (hit_disp) begin
            rd_byte = disp_q;
        end
    end

    // Bus answer registers: one wait-free access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= RD_ZERO;
        end else if (ce) begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup) begin
                prdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // Port registers; writes land at the completing edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_q <= '0;
            val_q <= '0;
        end else begin
            for (int i = 0; i < NPORT; i++) begin
                if (wr_en && hit_dir[i]) begin
                    dir_q[i] <= wbyte;        // see RULE2
                end
                if (wr_en && hit_val[i]) begin
                    val_q[i] <= wbyte;        // see RULE4, RULE8
                end
            end
        end
    end

    // Shared control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctype_q <= RST_BYTE;
            cfunc_q <= RST_BYTE;
            dfunc_q <= RST_BYTE;
            misc_q  <= RST_BYTE;
            disp_q  <= RST_BYTE;
        end else if (wr_en) begin
            if (hit_ctype) begin
                ctype_q <= wbyte;             // see RULE7, RULE9
            end
            if (hit_cfunc) begin
                cfunc_q <= wbyte;             // see RULE11
            end
            if (hit_dfunc) begin
                dfunc_q <= wbyte;             // see RULE11
            end
            if (hit_misc) begin
                misc_q  <= wbyte;             // see RULE6, RULE11
            end
            if (hit_disp) begin
                disp_q  <= wbyte;             // see RULE12
            end
        end
    end

    // Which pins are lent to system functions
    assign alt_sel_d[PA] = '0;
    assign alt_sel_d[PB] = '0;
    assign alt_sel_d[PC] = cfunc_q;                        // see RULE11
    assign alt_sel_d[PD] = dfunc_q;                        // see RULE11
    assign alt_sel_d[PE] = {{(PORT_W-MISC_EFUNC_W){1'b0}},
        misc_q[MISC_EFUNC_LSB +: MISC_EFUNC_W]};           // see RULE11
    assign alt_sel_d[PL] = {PORT_W{!disp_q[DISP_PWR_BIT]}}; // see RULE12

    assign pull_en = misc_q[MISC_PULL_BIT];

    // Pad drive per port; direction and type come from the GPIO
    // registers even when a function owns the data, so a function
    // switch never disturbs them (see RULE13)
    for (genvar i = 0; i < NPORT; i++) begin : g_pad     // see RULE1, RULE15
        logic [PORT_W-1:0] src;               // Data to drive
        assign src = (alt_sel_d[i] & alt_drv[i])
                   | (~alt_sel_d[i] & val_q[i]);
        assign pad_d[i].drv = src;            // see RULE8
        if (i == PC) begin : g_c
            // Type zero drops the high side: only lows are driven
            assign pad_d[i].oe_n = ~(dir_q[i]
                                   & (ctype_q | ~src));    // see RULE9
            // Value picks pull direction, type enables it
            assign pad_d[i].pu = ~dir_q[i] & val_q[i]
                               & ctype_q;                  // see RULE4, RULE7
            assign pad_d[i].pd = ~dir_q[i] & ~val_q[i]
                               & ctype_q;                  // see RULE4, RULE7
        end else begin : g_n
            assign pad_d[i].oe_n = ~dir_q[i];              // see RULE2, RULE9
            assign pad_d[i].pu = ~dir_q[i] & val_q[i]
                               & {PORT_W{pull_en}};        // see RULE6
            assign pad_d[i].pd = '0;                       // see RULE5
        end
    end

    // Port A debouncer feeding the transition request
    gxp_debounce #(
        .W   (PORT_W),
        .CYC (DEB_CYCLES)
    ) u_deb (                                              // see RULE10
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .raw      (pin_in[PA]),
        .level_q  (deb_level),
        .change_q (deb_change)
    );

    // Output flops for pads, function select and request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_q         <= {NPORT{PAD_RST}};           // see RULE2
            alt_sel_q     <= '0;
            alt_sel_q[PL] <= '1;                         // see RULE12
            porta_irq_q   <= 1'b0;
        end else if (ce) begin
            pad_q       <= pad_d;
            alt_sel_q   <= alt_sel_d;
            porta_irq_q <= deb_change;        // see RULE16
        end
    end

    // Port C never pulls both ways on one pin
    pull_exclusive_a: assert property ( // see RULE4
        @(posedge pclk) disable iff (!presetn)
        (pad_q[PC].pu & pad_q[PC].pd) == '0)
        else $error("port C pull-up and pull-down both on");

    // Direction bits steer the output enables of port B
    dir_enable_a: assert property ( // see RULE2
        @(posedge pclk) disable iff (!presetn)
        $past(ce) |-> pad_q[PB].oe_n == ~$past(dir_q[PB]))
        else $error("port B enable does not follow direction");

    // Reading port A with all pins input returns the pad level
    input_read_a: assert property ( // see RULE3
        @(posedge pclk) disable iff (!presetn)
        (setup && ce && !pwrite && addr_hit(paddr, OFF_VAL)
            && dir_q[PA] == '0)
        |=> prdata[PORT_W-1:0] == $past(pin_in[PA]))
        else $error("input read does not return pad level");

    // A completed write to port B value is held in val_q the next cycle
    write_back_a: assert property ( // see RULE8
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_val[PB])
        |=> val_q[PB] == $past(wbyte) && pad_q[PB].drv == $past(val_q[PB]))
        else $error("port B value not stored");

    // Plain ports never pull down
    no_pulldown_a: assert property ( // see RULE5
        @(posedge pclk) disable iff (!presetn)
        (pad_q[PA].pd | pad_q[PB].pd | pad_q[PD].pd
            | pad_q[PE].pd | pad_q[PL].pd) == '0)
        else $error("pull-down on a port without one");

    // Global pull enable gates the port A pull-ups
    pull_gate_a: assert property ( // see RULE6
        @(posedge pclk) disable iff (!presetn)
        ($past(ce) && !$past(misc_q[MISC_PULL_BIT])) |-> pad_q[PA].pu == '0)
        else $error("pull-up on while globally disabled");

    // Open-drain pins of port C never drive high
    open_drain_a: assert property ( // see RULE9
        @(posedge pclk) disable iff (!presetn)
        $past(ce) |->
            (~pad_q[PC].oe_n & pad_q[PC].drv & ~$past(ctype_q)) == '0)
        else $error("open-drain pin driven high");

    // Port L belongs to the display while it is powered
    display_owns_a: assert property ( // see RULE12
        @(posedge pclk) disable iff (!presetn)
        $past(ce) |->
            alt_sel_q[PL] == {PORT_W{!$past(disp_q[DISP_PWR_BIT])}})
        else $error("port L ownership wrong");

    // Port E low pins follow the misc function bits
    port_e_func_a: assert property ( // see RULE11
        @(posedge pclk) disable iff (!presetn)
        $past(ce) |->
            alt_sel_q[PE][MISC_EFUNC_W-1:0]
                == $past(misc_q[MISC_EFUNC_LSB +: MISC_EFUNC_W]))
        else $error("port E function select wrong");

    // The request is one pulse, one cycle after the debouncer's
    irq_pulse_a: assert property ( // see RULE16
        @(posedge pclk) disable iff (!presetn)
        (ce && deb_change) |=> porta_irq_q)
        else $error("port A request missed");

    // Every setup cycle with ce high is answered in the next cycle
    bus_answer_a: assert property ( // see RULE15
        @(posedge pclk) disable iff (!presetn)
        (setup && ce) |=> pready && (pslverr == !$past(mapped)))
        else $error("setup cycle not answered");

    // Straight after reset the port A and port L pins are undriven inputs
    reset_input_a: assert property ( // see RULE2
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> (&pad_q[PA].oe_n) && (&pad_q[PL].oe_n))
        else $error("pins driven straight after reset");

    // Port C input with value zero pulls down when enabled
    pull_down_a: assert property ( // see RULE4
        @(posedge pclk) disable iff (!presetn)
        $past(ce) && $past(ctype_q[0] && !dir_q[PC][0] && !val_q[PC][0])
        |-> pad_q[PC].pd[0])
        else $error("port C pull-down missing");
endmodule
`default_nettype wire

// ===== hdl/gxp_pkg.sv
// Package with map, field positions and pad types of the GPIO block
`default_nettype none
package gxp_pkg;
    // Port geometry
    localparam int PORT_W = 8;                // Pins per port
    localparam int NPORT  = 6;                // Ports A, B, C, D, E, L
    localparam int PA     = 0;                // Keyboard scan port
    localparam int PB     = 1;                // Plain port
    localparam int PC     = 2;                // Port with pull-down, open-drain
    localparam int PD     = 3;                // Port shared with chip selects
    localparam int PE     = 4;                // Port shared with clock pins
    localparam int PL     = 5;                // Port shared with display

    // APB map, byte addresses
    localparam int          ADDR_W    = 8;
    localparam logic [7:0]  OFF_DIR   = 8'h00;  // Direction, port i at +4*i
    localparam logic [7:0]  OFF_VAL   = 8'h20;  // Pin value, port i at +4*i
    localparam logic [7:0]  OFF_CTYPE = 8'h40;  // Port C type select
    localparam logic [7:0]  OFF_CFUNC = 8'h44;  // Port C function select
    localparam logic [7:0]  OFF_DFUNC = 8'h48;  // Port D function select
    localparam logic [7:0]  OFF_MISC  = 8'h4c;  // Port misc control
    localparam logic [7:0]  OFF_DISP  = 8'h50;  // Display control
    localparam logic [7:0]  PORT_STEP = 8'h04;  // Stride between ports

    // Field positions
    localparam int MISC_PULL_BIT  = 7;        // Global pull-up enable
    localparam int MISC_EFUNC_LSB = 0;        // Port E function bits
    localparam int MISC_EFUNC_W   = 3;
    localparam int DISP_PWR_BIT   = 7;        // Display power-off bit

    // Reset values
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

    // Debounce time for port A and its cycle count at 40 MHz
    localparam int CLK_PERIOD_NS = 25;
    localparam int DEB_TIME_NS   = 10000;
    localparam int DEB_CYC = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Drive of one port toward its pads
    typedef struct packed {
        logic [PORT_W-1:0] drv;               // Level to drive
        logic [PORT_W-1:0] oe_n;              // Low while pad is driven
        logic [PORT_W-1:0] pu;                // Pull-up on
        logic [PORT_W-1:0] pd;                // Pull-down on
    } gxp_pad_t;
endpackage
`default_nettype wire

// ===== sim/gxp_gpio_test.sv
// Self-checking bench for the six-port GPIO block
`timescale 1ns/1ps
`default_nettype none
module gxp_gpio_test;
    import gxp_pkg::*;
    localparam int DEB = 4;  // Short debounce for simulation
    logic                         pclk, presetn, ce, psel, penable, pwrite;
    logic [ADDR_W-1:0]            paddr;
    logic [31:0]                  pwdata, prdata, seed, rd;
    logic [3:0]                   pstrb;
    logic                         pready, pslverr, porta_irq_q, err, s;
    logic [NPORT-1:0][PORT_W-1:0] pin_in, alt_drv, alt_sel_q, ext_val, ext_en;
    gxp_pad_t [NPORT-1:0]         pad_q;
    logic [7:0]                   m_dir[NPORT], m_val[NPORT], a, d;
    logic [7:0]                   m_ct, m_cf, m_df, m_mi, m_di;
    int                           n_fail, total_checks, n, cyc = 0;

    gxp_gpio #(.DEB_CYCLES(DEB)) u_dut (.pclk(pclk), .presetn(presetn),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .alt_drv(alt_drv), .alt_sel_q(alt_sel_q), .pad_q(pad_q),
        .porta_irq_q(porta_irq_q));
    gxp_pin_model u_pins (.pclk(pclk), .pad(pad_q), .ext_val(ext_val),
        .ext_en(ext_en), .pin_lvl(pin_in));

    // Free-running 40 MHz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // One APB transfer: setup, access held until pready
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [7:0] dt, input logic sb);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= {rnd() & 32'hffff_ff00} | dt;
        pstrb   <= {3'h7, sb};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Table index to address: 6 direction, 6 value, 7 from 0x40 up
    function automatic logic [7:0] addr_of(input int i);
        return 8'(4 * i + (i < 6 ? 0 : i < 12 ? 8 : 16));
    endfunction
    function automatic logic [7:0] mval(input logic [7:0] ad);
        case (ad)
            OFF_CTYPE: return m_ct;
            OFF_CFUNC: return m_cf;
            OFF_DFUNC: return m_df;
            OFF_MISC:  return m_mi;
            OFF_DISP:  return m_di;
            default:   return ad < OFF_VAL ? m_dir[ad / 4] : 8'h00;
        endcase
    endfunction
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt,
                      input logic sb);
        apb(1'b1, ad, dt, sb);
        check(err, ad > OFF_DISP);
        if (sb && ad < OFF_CTYPE && ad >= OFF_VAL) begin
            m_val[(ad - OFF_VAL) / 4] = dt;
        end else if (sb) begin
            case (ad)
                OFF_CTYPE: m_ct = dt;
                OFF_CFUNC: m_cf = dt;
                OFF_DFUNC: m_df = dt;
                OFF_MISC:  m_mi = dt;
                OFF_DISP:  m_di = dt;
                default:   if (ad < OFF_VAL) m_dir[ad / 4] = dt;
            endcase
        end
    endtask
    task automatic rd_chk(input logic [7:0] ad);
        apb(1'b0, ad, 8'h00, 1'b1);
        check(rd, mval(ad));
        check(err, ad > OFF_DISP);
    endtask
    // Pins lent to system functions
    function automatic logic [7:0] sel_of(input int p);
        case (p)
            PC:      return m_cf;
            PD:      return m_df;
            PE:      return {5'h0, m_mi[MISC_EFUNC_W-1:0]};
            PL:      return {8{~m_di[DISP_PWR_BIT]}};
            default: return 8'h00;
        endcase
    endfunction
    // Expected pad drive of one port
    function automatic gxp_pad_t exp_pad(input int p);
        gxp_pad_t   e;
        logic [7:0] sl;
        sl = sel_of(p);
        e.drv  = (sl & alt_drv[p]) | (~sl & m_val[p]);
        e.oe_n = ~m_dir[p];
        e.pu   = ~m_dir[p] & m_val[p] & {8{m_mi[MISC_PULL_BIT]}};
        e.pd   = 8'h00;
        if (p == PC) begin
            e.oe_n = ~(m_dir[p] & (m_ct | ~e.drv));
            e.pu   = ~m_dir[p] & m_val[p] & m_ct;
            e.pd   = ~m_dir[p] & ~m_val[p] & m_ct;
        end
        return e;
    endfunction
    // Let pins settle, then compare every pad and value read
    task automatic check_all();
        gxp_pad_t   e;
        logic [7:0] lv, kn, dn;
        repeat (DEB + 8) @(posedge pclk);
        for (int p = 0; p < NPORT; p++) begin
            e = exp_pad(p);
            dn = ~e.oe_n;
            check(pad_q[p].oe_n, e.oe_n);
            check(pad_q[p].drv & dn, e.drv & dn);
            check(pad_q[p].pu, e.pu);
            check(pad_q[p].pd, e.pd);
            check(alt_sel_q[p], sel_of(p));
            lv = (e.drv & dn) | (e.oe_n & ((ext_en[p] & ext_val[p])
                 | (~ext_en[p] & e.pu)));
            kn = dn | ext_en[p] | e.pu | e.pd | m_dir[p];
            apb(1'b0, 8'(OFF_VAL + 4 * p), 8'h00, 1'b1);
            lv = (m_dir[p] & m_val[p]) | (~m_dir[p] & lv);
            check(rd & kn, lv & kn);
        end
    endtask
    // Count port A requests over a window
    task automatic count_irq();
        n = 0;
        repeat (DEB + 12) begin
            @(posedge pclk);
            if (porta_irq_q === 1'b1) n++;
        end
    endtask

    initial begin
        seed = 32'd72126;
        n_fail = 0;
        total_checks = 0;
        {ce, presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        ce = 1'b1;
        {ext_val, alt_drv} = '0;
        ext_en = '1;
        {m_ct, m_cf, m_df, m_mi, m_di} = '0;
        foreach (m_dir[i]) begin
            m_dir[i] = 8'h00;
            m_val[i] = 8'h00;
        end
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, then two unmapped places
        for (int i = 0; i < 19; i++) begin
            if (i < 6 || i > 11) rd_chk(addr_of(i));
        end
        check_all();
        // Random register traffic, refused strobes and pin activity
        for (int i = 0; i < 60; i++) begin
            a = addr_of(int'(rnd() % 19));
            d = rnd();
            s = (rnd() % 4) != 0;
            ext_val <= 48'({rnd(), rnd()});
            ext_en  <= 48'({rnd(), rnd()}) | 48'hff;
            alt_drv <= 48'({rnd(), rnd()});
            wr(a, d, s);
            if (a < OFF_VAL || a >= OFF_CTYPE) rd_chk(a);
            check_all();
        end
        // Direction set before the function select takes the pins
        wr(8'(OFF_DIR + 4 * PD), 8'hff, 1'b1);
        wr(OFF_DFUNC, 8'h3f, 1'b1);
        check_all();
        // Port A: two pins change together, then a short glitch
        wr(OFF_DIR, 8'h00, 1'b1);
        ext_val[PA] <= 8'h00;
        repeat (DEB + 8) @(posedge pclk);
        ext_val[PA] <= 8'h09;
        count_irq();
        check(n, 1);
        ext_val[PA] <= 8'h08;
        repeat (2) @(posedge pclk);
        ext_val[PA] <= 8'h09;
        count_irq();
        check(n, 0);
        // A low clock enable freezes the debouncer
        ce <= 1'b0;
        ext_val[PA] <= 8'h00;
        count_irq();
        check(n, 0);
        ce <= 1'b1;
        count_irq();
        check(n, 1);
        check_all();
        end_of_test();
    end
endmodule
`default_nettype wire

// ===== sim/gxp_pin_model.sv
// Model of the pads and the outside world seen by the GPIO block
`timescale 1ns/1ps
`default_nettype none
module gxp_pin_model
    import gxp_pkg::*;
(
    input  wire logic                         pclk,
    input  wire gxp_pad_t [NPORT-1:0]         pad,
    input  wire logic [NPORT-1:0][PORT_W-1:0] ext_val,
    input  wire logic [NPORT-1:0][PORT_W-1:0] ext_en,
    output logic      [NPORT-1:0][PORT_W-1:0] pin_lvl
);
    logic toggle_q;  // Floating pins wander, never hold the last value
    initial toggle_q = 1'b0;
    always @(posedge pclk) toggle_q <= ~toggle_q;
    // Own driver wins, then outside source, then pulls, else floating
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            for (int b = 0; b < PORT_W; b++) begin
                if (!pad[p].oe_n[b]) pin_lvl[p][b] = pad[p].drv[b];
                else if (ext_en[p][b]) pin_lvl[p][b] = ext_val[p][b];
                else if (pad[p].pu[b]) pin_lvl[p][b] = 1'b1;
                else if (pad[p].pd[b]) pin_lvl[p][b] = 1'b0;
                else pin_lvl[p][b] = toggle_q ^ b[0];
            end
        end
    end
endmodule
`default_nettype wire
